// >>> shf_handler_regs.sv
// System handler priority, control-and-state and fault status registers
//
// Notes on behaviour
// - Word a: mem, bus, usage priority bytes
// - Word b: supervisor call in top byte
// - Word c: tick, pendable service, monitor bytes
// - Byte, halfword, word access touch addressed bytes
// - Hardware and software both update state flags
// - Fault enables at bits 18, 17, 16
// - Pending set on occurrence, cleared on activation
// - Active flags while current or preempted
// - Fault word: usage, bus, protection parts
// - Writing one clears a fault bit
// - Fault bits accumulate until software clears
// - Protection bit 7: address register valid
// - Protection lazy fp, stacking, unstacking flags
// - Data violation sets bit 1, captures address
// - Fetch violation bit 0 only if issued
// - Bus address valid and derived fault flags
// - Precise bit 1 with address, imprecise bit 2
// - Prefetch error bit 0 only if issued
// - May report all bus data faults as imprecise
// - Usage halfword flags bits 9,8,3..0
`timescale 1ns/10ps

module shf_handler_regs #(
    parameter bit PRECISE_BUS_FAULTS = 1'b1    // Zero: data faults go imprecise
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RESET_N,
    // Register port
    input  wire logic [shf_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [1:0]               SIZE,
    input  wire logic [31:0]              WDATA,
    input  wire logic                     WR,
    input  wire logic                     RD,
    output logic      [31:0]              RDATA,
    // Core event side
    input  wire shf_pkg::shf_evt_t        EVT,
    output shf_pkg::shf_prio_t            PRIO,
    output shf_pkg::shf_state_t           STATE
);
    import shf_pkg::*;

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] prio_a;        // Priority word a
        logic [31:0] prio_b;        // Priority word b
        logic [31:0] prio_c;        // Priority word c
        logic [31:0] ctrl;          // Control and state
        logic [31:0] fault;         // Combined fault status
        logic [31:0] mm_addr;       // Protection fault address
        logic [31:0] bus_addr;      // Bus fault address
        logic [31:0] rdata;         // Read data, one cycle after strobe
    } shf_regs_t;

    shf_regs_t r_ff;                // Registered state
    shf_regs_t nxt_r;               // Next state

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic [3:0]  lanes;             // Addressed byte lanes
    logic [31:0] bmask;             // Lanes widened to bits
    logic [7:0]  word_addr;         // Address with lane bits removed
    logic [31:0] wbits;             // Write data limited to lanes
    logic [31:0] act_bits;          // Activation pulses at active positions
    logic [31:0] ret_bits;          // Return pulses at active positions
    logic [3:0]  pend_clr;          // Pending flags cleared by activation
    logic [31:0] fault_set;         // Fault bits set by hardware
    logic        precise_ok;        // Precise report taken
    logic        mm_fetch_q;        // Qualified fetch violation
    logic        bus_fetch_q;       // Qualified prefetch error

    // Byte lanes from size and low address bits
    always_comb begin
        case (SIZE)
            SIZE_BYTE: lanes = 4'h1 << ADDR[1:0];
            SIZE_HALF: lanes = ADDR[1] ? 4'hC : 4'h3;
            default:   lanes = 4'hF;
        endcase
    end

    // One mask bit per data bit
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign bmask[8*g +: 8] = {8{lanes[g]}};
        end
    endgenerate

    assign word_addr = {ADDR[7:2], 2'h0};
    assign wbits     = WDATA & bmask;

    // Expand a seven-flag active vector to its bit positions
    function automatic logic [31:0] place_act(input logic [6:0] v);
        logic [31:0] o;
        o = RESET_WORD;
        o[CS_SYSTICK] = v[6];
        o[CS_PENDSV]  = v[5];
        o[CS_MONITOR] = v[4];
        o[CS_SVC]     = v[3];
        o[CS_USG_ACT] = v[2];
        o[CS_BUS_ACT] = v[1];
        o[CS_MEM_ACT] = v[0];
        return o;
    endfunction : place_act

    // Gather a seven-flag active vector from its bit positions
    function automatic logic [6:0] take_act(input logic [31:0] w);
        return {w[CS_SYSTICK], w[CS_PENDSV], w[CS_MONITOR], w[CS_SVC],
                w[CS_USG_ACT], w[CS_BUS_ACT], w[CS_MEM_ACT]};
    endfunction : take_act

    assign act_bits = place_act(EVT.act_set);
    assign ret_bits = place_act(EVT.act_clr);
    // Svc, bus, mem, usage pending cleared when each is entered
    assign pend_clr = {EVT.act_set[3], EVT.act_set[1], EVT.act_set[0], EVT.act_set[2]};

    // Fault events qualified by issue and reporting option
    assign mm_fetch_q  = EVT.mm_fetch & EVT.fetch_issued;
    assign bus_fetch_q = EVT.bus_prefetch & EVT.fetch_issued;
    assign precise_ok  = PRECISE_BUS_FAULTS & EVT.bus_precise;

    // Hardware fault set pattern
    always_comb begin
        fault_set = RESET_WORD;
        fault_set[FS_MM_LSB + FB_LAZY_FP]       = EVT.mm_lazy_fp;
        fault_set[FS_MM_LSB + FB_ENTRY_STACK]   = EVT.mm_stack;
        fault_set[FS_MM_LSB + FB_RETURN_UNSTK]  = EVT.mm_unstack;
        fault_set[FS_MM_LSB + FB_DATA]          = EVT.mm_data;
        fault_set[FS_MM_LSB + FB_ADDR_VALID]    = EVT.mm_data;
        fault_set[FS_MM_LSB + FB_FETCH]         = mm_fetch_q;
        fault_set[FS_BUS_LSB + FB_LAZY_FP]      = EVT.bus_lazy_fp;
        fault_set[FS_BUS_LSB + FB_ENTRY_STACK]  = EVT.bus_stack;
        fault_set[FS_BUS_LSB + FB_RETURN_UNSTK] = EVT.bus_unstack;
        fault_set[FS_BUS_LSB + FB_DATA]         = precise_ok;
        fault_set[FS_BUS_LSB + FB_ADDR_VALID]   = precise_ok;
        // Precise errors fold into imprecise when not reported precisely
        fault_set[FS_BUS_LSB + FB_IMPRECISE]    = EVT.bus_imprecise
                                                | (EVT.bus_precise & ~precise_ok);
        fault_set[FS_BUS_LSB + FB_FETCH]        = bus_fetch_q;
        fault_set[FS_USG_LSB + FU_DIV_ZERO]     = EVT.usage_set[5];
        fault_set[FS_USG_LSB + FU_UNALIGNED]    = EVT.usage_set[4];
        fault_set[FS_USG_LSB + FU_COPROC]       = EVT.usage_set[3];
        fault_set[FS_USG_LSB + FU_RET_INTEG]    = EVT.usage_set[2];
        fault_set[FS_USG_LSB + FU_BAD_STATE]    = EVT.usage_set[1];
        fault_set[FS_USG_LSB + FU_UNDEF]        = EVT.usage_set[0];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        // Priority words, only addressed and implemented bytes change
        if (WR && word_addr == OFS_PRIO_A) begin
            nxt_r.prio_a = ((r_ff.prio_a & ~bmask) | wbits) & MASK_PRIO_A;
        end
        if (WR && word_addr == OFS_PRIO_B) begin
            nxt_r.prio_b = ((r_ff.prio_b & ~bmask) | wbits) & MASK_PRIO_B;
        end
        if (WR && word_addr == OFS_PRIO_C) begin
            nxt_r.prio_c = ((r_ff.prio_c & ~bmask) | wbits) & MASK_PRIO_C;
        end
        // Software may set or remove pending and active state
        if (WR && word_addr == OFS_CTRL) begin
            nxt_r.ctrl = ((r_ff.ctrl & ~bmask) | wbits) & MASK_CTRL;
        end
        // Exception processing on top; entry wins over a same-cycle return
        nxt_r.ctrl[CS_PEND_LSB +: 4] = (nxt_r.ctrl[CS_PEND_LSB +: 4] & ~pend_clr)
                                     | EVT.pend_set;
        nxt_r.ctrl = ((nxt_r.ctrl & ~ret_bits) | act_bits) & MASK_CTRL;
        // Write one to clear, hardware set wins over the clear
        if (WR && word_addr == OFS_FAULT) begin
            nxt_r.fault = r_ff.fault & ~wbits;
        end
        nxt_r.fault = (nxt_r.fault | fault_set) & MASK_FAULT;
        // Address capture for data faults
        if (EVT.mm_data) begin
            nxt_r.mm_addr = EVT.fault_addr;
        end
        if (precise_ok) begin
            nxt_r.bus_addr = EVT.fault_addr;
        end
        // Read data for the next cycle only
        nxt_r.rdata = RESET_WORD;
        if (RD) begin
            case (word_addr)
                OFS_PRIO_A:  nxt_r.rdata = r_ff.prio_a;
                OFS_PRIO_B:  nxt_r.rdata = r_ff.prio_b;
                OFS_PRIO_C:  nxt_r.rdata = r_ff.prio_c;
                OFS_CTRL:    nxt_r.rdata = r_ff.ctrl;
                OFS_FAULT:   nxt_r.rdata = r_ff.fault;
                OFS_MM_ADDR: nxt_r.rdata = r_ff.mm_addr;
                OFS_BUS_ADR: nxt_r.rdata = r_ff.bus_addr;
                default:     nxt_r.rdata = RESET_WORD;                // Unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign RDATA = r_ff.rdata;

    assign PRIO.protection_fault = r_ff.prio_a[7:0];
    assign PRIO.bus_fault        = r_ff.prio_a[15:8];
    assign PRIO.usage_fault      = r_ff.prio_a[23:16];
    assign PRIO.supervisor_call  = r_ff.prio_b[31:24];
    assign PRIO.debug_monitor    = r_ff.prio_c[7:0];
    assign PRIO.pendable_service = r_ff.prio_c[23:16];
    assign PRIO.system_tick      = r_ff.prio_c[31:24];

    assign STATE.usage_fault_enable      = r_ff.ctrl[CS_USG_EN];
    assign STATE.bus_fault_enable        = r_ff.ctrl[CS_BUS_EN];
    assign STATE.protection_fault_enable = r_ff.ctrl[CS_MEM_EN];
    assign STATE.pending                 = r_ff.ctrl[CS_PEND_LSB +: 4];
    assign STATE.active                  = take_act(r_ff.ctrl);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_pend_clear_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.act_set[0] && !EVT.pend_set[1] && !WR |=> !STATE.pending[1])
        else $error("mem pending not cleared on entry");

    chk_active_set_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.act_set[6] |=> r_ff.ctrl[CS_SYSTICK] && STATE.active[6])
        else $error("systick active not set on entry");

    chk_fault_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
        r_ff.fault[FS_BUS_LSB + FB_IMPRECISE] && !(WR && word_addr == OFS_FAULT)
        |=> r_ff.fault[FS_BUS_LSB + FB_IMPRECISE])
        else $error("fault bit lost without clear");

    chk_w1c_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
        WR && word_addr == OFS_FAULT && wbits[FS_USG_LSB + FU_UNDEF]
        && !EVT.usage_set[0] |=> !r_ff.fault[FS_USG_LSB + FU_UNDEF])
        else $error("write one did not clear fault bit");

    chk_data_addr_cap: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.mm_data |=> r_ff.mm_addr == $past(EVT.fault_addr)
        && r_ff.fault[FS_MM_LSB + FB_ADDR_VALID] && r_ff.fault[FS_MM_LSB + FB_DATA])
        else $error("data violation not captured");

    chk_precise_cap: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.bus_precise && PRECISE_BUS_FAULTS |=> r_ff.bus_addr == $past(EVT.fault_addr)
        && r_ff.fault[FS_BUS_LSB + FB_DATA])
        else $error("precise bus error not captured");

    chk_fetch_issued: assert property (@(posedge CLK) disable iff (!RESET_N)
        !r_ff.fault[FS_MM_LSB + FB_FETCH] && !EVT.fetch_issued
        |=> !r_ff.fault[FS_MM_LSB + FB_FETCH])
        else $error("fetch violation flagged without issue");

    chk_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        ((r_ff.prio_b & ~MASK_PRIO_B) == RESET_WORD) && ((r_ff.ctrl & ~MASK_CTRL) == RESET_WORD)
        && ((r_ff.fault & ~MASK_FAULT) == RESET_WORD))
        else $error("reserved bit set");

    chk_byte_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        WR && word_addr == OFS_PRIO_A
        |=> (r_ff.prio_a & ~$past(bmask)) == ($past(r_ff.prio_a) & ~$past(bmask)))
        else $error("write disturbed unaddressed bytes");

    chk_read_latency: assert property (@(posedge CLK) disable iff (!RESET_N)
        RD && word_addr == OFS_PRIO_C |=> RDATA == $past(r_ff.prio_c) ##1 RDATA == RESET_WORD
        || $past(RD))
        else $error("read data wrong or late");

    chk_pend_set_event: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.pend_set[3] |=> STATE.pending[3])
        else $error("svc pending not set on occurrence");

    chk_prefetch_issued: assert property (@(posedge CLK) disable iff (!RESET_N)
        !r_ff.fault[FS_BUS_LSB + FB_FETCH] && !EVT.fetch_issued
        |=> !r_ff.fault[FS_BUS_LSB + FB_FETCH])
        else $error("prefetch error flagged without issue");

    chk_derived_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.mm_stack && EVT.bus_stack
        |=> r_ff.fault[FS_MM_LSB + FB_ENTRY_STACK] && r_ff.fault[FS_BUS_LSB + FB_ENTRY_STACK])
        else $error("stacking fault not flagged");

    chk_usage_flag_set: assert property (@(posedge CLK) disable iff (!RESET_N)
        EVT.usage_set[5] |=> r_ff.fault[FS_USG_LSB + FU_DIV_ZERO])
        else $error("divide by zero flag not set");

endmodule : shf_handler_regs

// >>> shf_pkg.sv
// Package: register map, field layout and carrier types of the system handler block
package shf_pkg;

    // ------------------------------------------------------------------
    // Register bus shape
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [1:0]  SIZE_BYTE   = 2'h0;     // One byte lane
    localparam logic [1:0]  SIZE_HALF   = 2'h1;     // Aligned halfword
    localparam logic [1:0]  SIZE_WORD   = 2'h2;     // Full word

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_PRIO_A  = 8'h00;    // handler_priority_word_a
    localparam logic [7:0]  OFS_PRIO_B  = 8'h04;    // handler_priority_word_b
    localparam logic [7:0]  OFS_PRIO_C  = 8'h08;    // handler_priority_word_c
    localparam logic [7:0]  OFS_CTRL    = 8'h0C;    // handler_control_state
    localparam logic [7:0]  OFS_FAULT   = 8'h10;    // combined_fault_status
    localparam logic [7:0]  OFS_MM_ADDR = 8'h14;    // protection_fault_address
    localparam logic [7:0]  OFS_BUS_ADR = 8'h18;    // bus_fault_address

    // ------------------------------------------------------------------
    // Implemented bits of each register; all others read zero
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_PRIO_A = 32'h00FFFFFF;
    localparam logic [31:0] MASK_PRIO_B = 32'hFF000000;
    localparam logic [31:0] MASK_PRIO_C = 32'hFFFF00FF;
    localparam logic [31:0] MASK_CTRL   = 32'h0007FD8B;
    localparam logic [31:0] MASK_FAULT  = 32'h030FBFBB;
    localparam logic [31:0] RESET_WORD  = 32'h00000000;

    // ------------------------------------------------------------------
    // Control and state field positions
    // ------------------------------------------------------------------
    localparam int CS_USG_EN   = 18;
    localparam int CS_BUS_EN   = 17;
    localparam int CS_MEM_EN   = 16;
    localparam int CS_PEND_LSB = 12;                 // Pending flags 15:12
    localparam int CS_SYSTICK  = 11;
    localparam int CS_PENDSV   = 10;
    localparam int CS_MONITOR  = 8;
    localparam int CS_SVC      = 7;
    localparam int CS_USG_ACT  = 3;
    localparam int CS_BUS_ACT  = 1;
    localparam int CS_MEM_ACT  = 0;

    // ------------------------------------------------------------------
    // Fault status field positions (combined word)
    // ------------------------------------------------------------------
    localparam int FS_MM_LSB       = 0;
    localparam int FS_BUS_LSB      = 8;
    localparam int FS_USG_LSB      = 16;
    localparam int FB_ADDR_VALID   = 7;              // Within a byte
    localparam int FB_LAZY_FP      = 5;
    localparam int FB_ENTRY_STACK  = 4;
    localparam int FB_RETURN_UNSTK = 3;
    localparam int FB_IMPRECISE    = 2;
    localparam int FB_DATA         = 1;
    localparam int FB_FETCH        = 0;
    localparam int FU_DIV_ZERO     = 9;              // Within the halfword
    localparam int FU_UNALIGNED    = 8;
    localparam int FU_COPROC       = 3;
    localparam int FU_RET_INTEG    = 2;
    localparam int FU_BAD_STATE    = 1;
    localparam int FU_UNDEF        = 0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Events from the core exception and fault logic, one-cycle pulses
    typedef struct packed {
        logic [3:0]  pend_set;      // svc, bus, mem, usage occurred
        logic [6:0]  act_set;       // systick,pendsv,mon,svc,usg,bus,mem entered
        logic [6:0]  act_clr;       // Same order, handler returned
        logic        mm_lazy_fp;
        logic        mm_stack;
        logic        mm_unstack;
        logic        mm_data;       // Data access violation
        logic        mm_fetch;      // Fetch violation
        logic        bus_lazy_fp;
        logic        bus_stack;
        logic        bus_unstack;
        logic        bus_precise;
        logic        bus_imprecise;
        logic        bus_prefetch;
        logic        fetch_issued;  // Faulting instruction was issued
        logic [5:0]  usage_set;     // div0, unaligned, coproc, integ, state, undef
        logic [31:0] fault_addr;    // Address of the faulting data access
    } shf_evt_t;

    // Handler priorities toward the core
    typedef struct packed {
        logic [7:0] protection_fault;
        logic [7:0] bus_fault;
        logic [7:0] usage_fault;
        logic [7:0] supervisor_call;
        logic [7:0] debug_monitor;
        logic [7:0] pendable_service;
        logic [7:0] system_tick;
    } shf_prio_t;

    // Enables and exception state toward the core
    typedef struct packed {
        logic       usage_fault_enable;
        logic       bus_fault_enable;
        logic       protection_fault_enable;
        logic [3:0] pending;        // svc, bus, mem, usage
        logic [6:0] active;         // Same order as act_set
    } shf_state_t;

endpackage : shf_pkg

// >>> shf_core_model.sv
// Core-side model: turns bench requests into one-cycle event pulses
`timescale 1ns/10ps

module shf_core_model (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    // Bench request
    input  wire logic              GO,
    input  wire shf_pkg::shf_evt_t REQ,
    // Events toward the block
    output shf_pkg::shf_evt_t      EVT
);
    import shf_pkg::*;

    shf_evt_t idle;                 // Quiet pulses with inverted address

    // Idle pattern: no pulses, address flipped so it is never held
    always_comb begin
        idle            = '0;
        idle.fault_addr = ~EVT.fault_addr;
    end

    // One pulse per request; idle address is scrambled, never held
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            EVT <= '0;
        end else if (!GO) begin
            EVT <= idle;
        end else begin
            EVT <= REQ;
        end
    end
endmodule : shf_core_model

// >>> tb_top.sv
// Self-checking bench for the system handler register block
`timescale 1ns/10ps

module tb_top;
    import shf_pkg::*;

    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic        clk     = 1'h0;
    logic        reset_n = 1'h0;
    logic [7:0]  addr    = 8'h00;
    logic [1:0]  size    = 2'h2;
    logic [31:0] wdata   = 32'h0;
    logic        wr_stb  = 1'h0;
    logic        rd_stb  = 1'h0;
    logic        go      = 1'h0;
    shf_evt_t    req     = '0;
    logic [31:0] rdata;
    logic [31:0] rdata_ip;
    shf_evt_t    evt;
    shf_prio_t   prio;
    shf_state_t  state;
    shf_evt_t    e;
    logic [31:0] v;
    int          error_cnt = 0;
    int          checks    = 0;

    always #5 clk = ~clk;

    shf_handler_regs i_shf_handler_regs (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
        .SIZE(size), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata),
        .EVT(evt), .PRIO(prio), .STATE(state));
    shf_handler_regs #(.PRECISE_BUS_FAULTS(1'b0)) i_shf_handler_regs_imprecise (.CLK(clk),
        .RESET_N(reset_n), .ADDR(addr), .SIZE(size), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
        .RDATA(rdata_ip), .EVT(evt), .PRIO(), .STATE());
    shf_core_model i_shf_core_model (.CLK(clk), .RESET_N(reset_n), .GO(go),
        .REQ(req), .EVT(evt));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bus_wr(input logic [7:0] a, input logic [1:0] s, input logic [31:0] d);
        @(posedge clk);
        wr_stb <= 1'h1;
        addr   <= a;
        size   <= s;
        wdata  <= d;
        @(posedge clk);
        wr_stb <= 1'h0;
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_stb <= 1'h1;
        addr   <= a;
        @(posedge clk);
        rd_stb <= 1'h0;
        #1 d = rdata;
    endtask : bus_rd

    task rc(input logic [7:0] a, input logic [31:0] exp);
        bus_rd(a, v);
        chk(v, exp);
    endtask : rc

    // Pulse reaches the block one edge after the request
    task fire(input shf_evt_t x);
        @(posedge clk);
        go  <= 1'h1;
        req <= x;
        @(posedge clk);
        go  <= 1'h0;
        @(posedge clk);
    endtask : fire

    task report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rc(8'(i * 4), 32'h0);
        end
        for (int i = 0; i < 3; i++) begin
            bus_wr(8'(i * 4), SIZE_WORD, 32'hFFFFFFFF);
        end
        rc(OFS_PRIO_A, MASK_PRIO_A);
        rc(OFS_PRIO_B, MASK_PRIO_B);
        rc(OFS_PRIO_C, MASK_PRIO_C);
        chk({8'h00, prio[55:32]}, 32'h00FFFFFF);
        bus_wr(8'h01, SIZE_BYTE, 32'h0000AB00);
        bus_wr(8'h0A, SIZE_HALF, 32'h5AA50000);
        rc(OFS_PRIO_A, 32'h00FFABFF);
        rc(OFS_PRIO_C, 32'h5AA500FF);
        chk({8'h00, prio[55:32]}, 32'h00FFABFF);
        chk(prio[31:0], 32'hFFFFA55A);
        // Control word: software sets every flag, then read-modify-write
        bus_wr(OFS_CTRL, SIZE_WORD, 32'hFFFFFFFF);
        rc(OFS_CTRL, MASK_CTRL);
        chk({18'h0, state}, 32'h00003FFF);
        bus_wr(OFS_CTRL, SIZE_WORD, 32'h0);
        bus_rd(OFS_CTRL, v);
        bus_wr(OFS_CTRL, SIZE_WORD, v | 32'h00010000);
        rc(OFS_CTRL, 32'h00010000);
        // Core raises, enters and leaves every exception
        e = '0;
        e.pend_set = 4'hF;
        fire(e);
        rc(OFS_CTRL, 32'h0001F000);
        chk({18'h0, state}, 32'h00000F80);
        e = '0;
        e.act_set = 7'h7F;
        fire(e);
        rc(OFS_CTRL, 32'h00010D8B);
        chk({18'h0, state}, 32'h0000087F);
        e = '0;
        e.act_clr = 7'h7F;
        fire(e);
        rc(OFS_CTRL, 32'h00010000);
        // Faults: unissued fetches, then data, then all causes
        e = '0;
        e.mm_fetch     = 1'h1;
        e.bus_prefetch = 1'h1;
        fire(e);
        rc(OFS_FAULT, 32'h0);
        e = '0;
        e.mm_data    = 1'h1;
        e.fault_addr = 32'hC0DE1234;
        fire(e);
        rc(OFS_FAULT, 32'h00000082);
        rc(OFS_MM_ADDR, 32'hC0DE1234);
        e = '1;
        e.pend_set   = '0;
        e.act_set    = '0;
        e.act_clr    = '0;
        e.fault_addr = 32'h0000BEEF;
        fire(e);
        rc(OFS_FAULT, MASK_FAULT);
        chk(rdata_ip, 32'h030F3DBB);
        rc(OFS_BUS_ADR, 32'h0000BEEF);
        chk(rdata_ip, 32'h0);
        bus_wr(8'h11, SIZE_BYTE, 32'h00000400);
        rc(OFS_FAULT, 32'h030FBBBB);
        bus_wr(8'h12, SIZE_HALF, 32'h03000000);
        rc(OFS_FAULT, 32'h000FBBBB);
        bus_wr(OFS_FAULT, SIZE_WORD, 32'hFFFFFFFF);
        rc(OFS_FAULT, 32'h0);
        // Mid-run reset clears written state
        bus_wr(OFS_CTRL, SIZE_WORD, 32'hFFFFFFFF);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        rc(OFS_CTRL, 32'h0);
        chk({8'h00, prio[55:32]}, 32'h0);
        report_and_stop();
    end

    // Watchdog, far beyond the roughly 120 cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
